// >>> fsp_pkg.sv
// Shared constants, types and helpers for the FIFO serial port
package fsp_pkg;

    // ----------------------------------------
    // Register map and bus
    // ----------------------------------------
    localparam int FSP_AW = 8;
    localparam logic [7:0] FSP_CTRL_OFS = 8'h00;
    localparam logic [7:0] FSP_BAUD_OFS = 8'h04;
    localparam logic [7:0] FSP_TXDATA_OFS = 8'h08;
    localparam logic [7:0] FSP_RXDATA_OFS = 8'h0C;
    localparam logic [7:0] FSP_STATUS_OFS = 8'h10;

    // ----------------------------------------
    // Sizes and reset values
    // ----------------------------------------
    localparam int FSP_FIFO_DEPTH = 16;
    localparam int FSP_CNT_W = 5;
    localparam int FSP_DIV_W = 16;
    localparam logic [7:0] FSP_CTRL_RST = 8'h00;
    localparam logic [15:0] FSP_BAUD_RST = 16'h000D;
    localparam logic [31:0] FSP_ZERO_WORD = 32'h0000_0000;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int FSP_RXD_PER_BIT = 8;
    localparam int FSP_RXD_FER_BIT = 9;
    localparam int FSP_RXD_EMPTY_BIT = 31;
    localparam int FSP_ST_TX_FULL = 0;
    localparam int FSP_ST_TX_EMPTY = 1;
    localparam int FSP_ST_RX_EMPTY = 2;
    localparam int FSP_ST_RX_FULL = 3;
    localparam int FSP_ST_OVR = 4;
    localparam int FSP_ST_BRK = 5;
    localparam int FSP_ST_PER = 6;
    localparam int FSP_ST_FER = 7;
    localparam int FSP_ST_RXD_LVL = 8;
    localparam int FSP_ST_TX_BUSY = 9;
    localparam int FSP_ST_TX_CNT = 16;
    localparam int FSP_ST_RX_CNT = 24;

    // ----------------------------------------
    // Timing counts
    // ----------------------------------------
    localparam logic [3:0] FSP_OVS_LAST = 4'hF;
    localparam logic [3:0] FSP_MID_LAST = 4'h7;
    localparam logic [2:0] FSP_LAST_BIT8 = 3'h7;
    localparam logic [2:0] FSP_LAST_BIT7 = 3'h6;
    localparam logic [7:0] FSP_OVS_FACTOR = 8'h10;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    // Field order puts sync_mode at bit 0 and rx_en at bit 7
    typedef struct packed {
        logic rx_en;
        logic tx_en;
        logic ext_clk;
        logic stop2;
        logic par_odd;
        logic par_en;
        logic len7;
        logic sync_mode;
    } fsp_ctrl_t;

    typedef struct packed {
        logic fer;
        logic per;
        logic [7:0] data;
    } fsp_rx_entry_t;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} fsp_tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} fsp_rx_state_t;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic fsp_parity(input logic [7:0] data, input fsp_ctrl_t c);
        logic p;
        p = c.len7 ? ^data[6:0] : ^data;
        return p ^ c.par_odd;
    endfunction : fsp_parity

    function automatic logic [7:0] fsp_frame_ticks(input fsp_ctrl_t c);
        logic [3:0] bits;
        bits = 4'h1 + (c.len7 ? 4'h7 : 4'h8) + {3'h0, c.par_en} + (c.stop2 ? 4'h2 : 4'h1);
        return {4'h0, bits} * FSP_OVS_FACTOR;
    endfunction : fsp_frame_ticks

endpackage : fsp_pkg

// >>> fsp_fifo.sv
// Parameterised first-in first-out buffer with valid/ready on both sides
module fsp_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready,
    output logic [$clog2(D+1)-1:0] count
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D+1);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] level;
    logic push;
    logic pop;

    assign in_ready = level != CW'(D);
    assign out_valid = level != '0;
    assign out_data = mem[rd_ptr];
    assign count = level;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            level <= '0;
        end else begin
            unique case ({push, pop})
                2'b10: level <= level + 1'b1;
                2'b01: level <= level - 1'b1;
                default: level <= level;
            endcase
        end
    end

endmodule : fsp_fifo

// >>> fsp_fifo_serial_port.sv
// FIFO serial port: async and clocked sync serial link behind an APB slave
module fsp_fifo_serial_port (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fsp_pkg::FSP_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic txd,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe
);
    import fsp_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    fsp_ctrl_t ctrl;
    logic [FSP_DIV_W-1:0] baud_div;
    logic [FSP_DIV_W-1:0] baud_cnt;
    logic [1:0] rxd_sync;
    logic [1:0] sck_sync;
    logic rxd_s;
    logic rxd_prev;
    logic sck_prev;
    logic int_tick;
    logic ext_rise;
    logic ext_fall;
    logic tick16;
    logic access;
    logic done;
    logic unmapped;
    logic tx_full_err;
    logic [31:0] read_mux;
    logic tx_push;
    logic tx_in_ready;
    logic tx_avail;
    logic tx_pop;
    logic [7:0] tx_head;
    logic [FSP_CNT_W-1:0] tx_count;
    logic rx_push;
    logic rx_in_ready;
    logic rx_avail;
    logic rx_pop;
    fsp_rx_entry_t rx_word;
    fsp_rx_entry_t rx_head;
    logic [FSP_CNT_W-1:0] rx_count;
    fsp_tx_state_t tx_state;
    logic [7:0] tx_shift;
    logic [2:0] tx_bit;
    logic [3:0] tx_ticks;
    logic tx_par;
    fsp_rx_state_t rx_state;
    logic [7:0] rx_shift;
    logic [2:0] rx_bit;
    logic [3:0] rx_ticks;
    logic rx_per;
    logic rxa_push;
    fsp_rx_entry_t rxa_word;
    logic sy_active;
    logic [2:0] sy_cnt;
    logic [7:0] sy_tx;
    logic [7:0] sy_rx;
    logic sy_rise;
    logic sy_fall;
    logic sy_push;
    logic [7:0] sy_word;
    logic ovr;
    logic brk;
    logic per_st;
    logic fer_st;
    logic brk_armed;
    logic [7:0] brk_ticks;
    logic fer_event;
    logic st_wr;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rxd_sync <= 2'b11;
            sck_sync <= 2'b11;
            rxd_prev <= 1'b1;
            sck_prev <= 1'b1;
        end else begin
            rxd_sync <= {rxd_sync[0], rxd};
            sck_sync <= {sck_sync[0], sck_in};
            rxd_prev <= rxd_sync[1];
            sck_prev <= sck_sync[1];
        end
    end

    assign rxd_s = rxd_sync[1];
    assign ext_rise = sck_sync[1] & ~sck_prev;
    assign ext_fall = ~sck_sync[1] & sck_prev;

    // ----------------------------------------
    // Bit clock source
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            baud_cnt <= '0;
        end else begin
            baud_cnt <= int_tick ? baud_div : baud_cnt - 1'b1;
        end
    end

    assign int_tick = baud_cnt == '0;
    assign tick16 = ctrl.ext_clk ? ext_rise : int_tick;
    assign sy_rise = ctrl.ext_clk ? ext_rise : (int_tick & sy_active & ~sck_out);
    assign sy_fall = ctrl.ext_clk ? ext_fall : (int_tick & sy_active & sck_out);

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // One wait state: data and error are ready a cycle after the access phase opens
    assign access = psel & penable & ~pready;
    assign done = psel & penable & pready;
    assign unmapped = !(paddr inside {FSP_CTRL_OFS, FSP_BAUD_OFS, FSP_TXDATA_OFS,
                                      FSP_RXDATA_OFS, FSP_STATUS_OFS});
    assign tx_full_err = pwrite & (paddr == FSP_TXDATA_OFS) & ~tx_in_ready;
    assign tx_push = done & pwrite & ~pslverr & (paddr == FSP_TXDATA_OFS);
    // Pop only what the answer carried; a push after the capture must not be lost
    assign rx_pop = done & ~pwrite & (paddr == FSP_RXDATA_OFS) & ~prdata[FSP_RXD_EMPTY_BIT];
    assign st_wr = done & pwrite & (paddr == FSP_STATUS_OFS);

    always_comb begin
        read_mux = FSP_ZERO_WORD;
        unique case (paddr)
            FSP_CTRL_OFS: read_mux[7:0] = ctrl;
            FSP_BAUD_OFS: read_mux[FSP_DIV_W-1:0] = baud_div;
            FSP_RXDATA_OFS: begin
                read_mux[FSP_RXD_FER_BIT:0] = rx_head;
                read_mux[FSP_RXD_EMPTY_BIT] = ~rx_avail;
            end
            FSP_STATUS_OFS: begin
                read_mux[FSP_ST_TX_FULL] = ~tx_in_ready;
                read_mux[FSP_ST_TX_EMPTY] = ~tx_avail;
                read_mux[FSP_ST_RX_EMPTY] = ~rx_avail;
                read_mux[FSP_ST_RX_FULL] = ~rx_in_ready;
                read_mux[FSP_ST_OVR] = ovr;
                read_mux[FSP_ST_BRK] = brk;
                read_mux[FSP_ST_PER] = per_st;
                read_mux[FSP_ST_FER] = fer_st;
                read_mux[FSP_ST_RXD_LVL] = rxd_s;
                read_mux[FSP_ST_TX_BUSY] = (tx_state != TX_IDLE) | sy_active;
                read_mux[FSP_ST_TX_CNT +: FSP_CNT_W] = tx_count;
                read_mux[FSP_ST_RX_CNT +: FSP_CNT_W] = rx_count;
            end
            default: read_mux = FSP_ZERO_WORD;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= FSP_ZERO_WORD;
        end else begin
            pready <= access;
            pslverr <= access & (unmapped | tx_full_err);
            prdata <= (access & ~pwrite) ? read_mux : FSP_ZERO_WORD;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ctrl <= fsp_ctrl_t'(FSP_CTRL_RST);
            baud_div <= FSP_BAUD_RST;
        end else if (done & pwrite) begin
            if (paddr == FSP_CTRL_OFS) begin
                ctrl <= fsp_ctrl_t'(pwdata[7:0]);
            end
            if (paddr == FSP_BAUD_OFS) begin
                baud_div <= pwdata[FSP_DIV_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // Buffers
    // ----------------------------------------
    // independent sixteen-entry buffers
    fsp_fifo #(.W(8), .D(FSP_FIFO_DEPTH)) u_tx_fifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(tx_push),
        .in_data(pwdata[7:0]),
        .in_ready(tx_in_ready),
        .out_valid(tx_avail),
        .out_data(tx_head),
        .out_ready(tx_pop),
        .count(tx_count)
    );

    fsp_fifo #(.W(10), .D(FSP_FIFO_DEPTH)) u_rx_fifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(rx_push),
        .in_data(rx_word),
        .in_ready(rx_in_ready),
        .out_valid(rx_avail),
        .out_data(rx_head),
        .out_ready(rx_pop),
        .count(rx_count)
    );

    // each mode feeds the receive buffer alone
    assign rx_push = rxa_push | sy_push;
    assign rx_word = sy_push ? fsp_rx_entry_t'({2'b00, sy_word}) : rxa_word;
    assign tx_pop = (tx_state == TX_IDLE && ctrl.tx_en && !ctrl.sync_mode && tx_avail)
                  | (sy_fall && sy_cnt == 3'h0 && ctrl.tx_en && tx_avail);

    // ----------------------------------------
    // Async transmitter
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            tx_state <= TX_IDLE;
            tx_shift <= 8'h00;
            tx_bit <= 3'h0;
            tx_ticks <= 4'h0;
            tx_par <= 1'b0;
        end else if (tx_state == TX_IDLE) begin
            if (tx_pop && !ctrl.sync_mode) begin
                tx_state <= TX_START;
                tx_shift <= tx_head;
                tx_par <= fsp_parity(tx_head, ctrl);
                tx_ticks <= 4'h0;
                tx_bit <= 3'h0;
            end
        end else if (tick16) begin
            tx_ticks <= tx_ticks + 1'b1;
            if (tx_ticks == FSP_OVS_LAST) begin
                // start, data LSB first, parity, stop
                unique case (tx_state)
                    TX_START: tx_state <= TX_DATA;
                    TX_DATA: begin
                        tx_shift <= {1'b1, tx_shift[7:1]};
                        tx_bit <= tx_bit + 1'b1;
                        if (tx_bit == (ctrl.len7 ? FSP_LAST_BIT7 : FSP_LAST_BIT8)) begin
                            tx_bit <= 3'h0;
                            tx_state <= ctrl.par_en ? TX_PAR : TX_STOP;
                        end
                    end
                    TX_PAR: tx_state <= TX_STOP;
                    TX_STOP: begin
                        if (ctrl.stop2 && tx_bit == 3'h0) begin
                            tx_bit <= 3'h1;
                        end else begin
                            tx_state <= TX_IDLE;
                        end
                    end
                    default: tx_state <= TX_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            txd <= 1'b1;
        end else if (ctrl.sync_mode) begin
            txd <= sy_active | ctrl.ext_clk ? sy_tx[0] : 1'b1;
        end else begin
            unique case (tx_state)
                TX_START: txd <= 1'b0;
                TX_DATA: txd <= tx_shift[0];
                TX_PAR: txd <= tx_par;
                default: txd <= 1'b1;
            endcase
        end
    end

    // ----------------------------------------
    // Async receiver
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rx_state <= RX_IDLE;
            rx_shift <= 8'h00;
            rx_bit <= 3'h0;
            rx_ticks <= 4'h0;
            rx_per <= 1'b0;
            rxa_push <= 1'b0;
            rxa_word <= '0;
        end else begin
            rxa_push <= 1'b0;
            if (rx_state == RX_IDLE) begin
                // falling edge marks a start bit
                if (ctrl.rx_en && !ctrl.sync_mode && rxd_prev && !rxd_s) begin
                    rx_state <= RX_START;
                    rx_ticks <= 4'h0;
                    rx_bit <= 3'h0;
                    rx_per <= 1'b0;
                end
            end else if (tick16) begin
                rx_ticks <= rx_ticks + 1'b1;
                // eighth pulse in start bit, then every sixteen
                if (rx_state == RX_START && rx_ticks == FSP_MID_LAST) begin
                    rx_ticks <= 4'h0;
                    rx_state <= rxd_s ? RX_IDLE : RX_DATA;
                end else if (rx_state != RX_START && rx_ticks == FSP_OVS_LAST) begin
                    unique case (rx_state)
                        RX_DATA: begin
                            rx_shift <= {rxd_s, rx_shift[7:1]};
                            rx_bit <= rx_bit + 1'b1;
                            if (rx_bit == (ctrl.len7 ? FSP_LAST_BIT7 : FSP_LAST_BIT8)) begin
                                rx_state <= ctrl.par_en ? RX_PAR : RX_STOP;
                            end
                        end
                        RX_PAR: begin
                            rx_per <= rxd_s != fsp_parity(ctrl.len7 ? {1'b0, rx_shift[7:1]}
                                                                    : rx_shift, ctrl);
                            rx_state <= RX_STOP;
                        end
                        RX_STOP: begin
                            // framing error on low stop bit
                            rxa_push <= 1'b1;
                            rxa_word <= '{fer: ~rxd_s, per: rx_per,
                                          data: ctrl.len7 ? {1'b0, rx_shift[7:1]} : rx_shift};
                            rx_state <= RX_IDLE;
                        end
                        default: rx_state <= RX_IDLE;
                    endcase
                end
            end
        end
    end

    // ----------------------------------------
    // Clocked sync engine
    // ----------------------------------------
    // fixed eight bits, shifted out on falling and taken on rising edge
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sy_active <= 1'b0;
            sy_cnt <= 3'h0;
            sy_tx <= 8'hFF;
            sy_rx <= 8'h00;
            sy_push <= 1'b0;
            sy_word <= 8'h00;
            sck_out <= 1'b1;
            sck_oe <= 1'b0;
        end else begin
            sy_push <= 1'b0;
            sck_oe <= ctrl.sync_mode & ~ctrl.ext_clk;
            if (!ctrl.sync_mode) begin
                sy_active <= 1'b0;
                sy_cnt <= 3'h0;
                sck_out <= 1'b1;
            end else begin
                // Internal clock only runs while there is work to do
                if (!ctrl.ext_clk && !sy_active && sck_out
                    && ((ctrl.tx_en && tx_avail) || (!ctrl.tx_en && ctrl.rx_en && rx_in_ready))) begin
                    sy_active <= 1'b1;
                end
                if (!ctrl.ext_clk && sy_active && int_tick) begin
                    sck_out <= ~sck_out;
                end
                if (sy_fall) begin
                    if (sy_cnt == 3'h0) begin
                        sy_tx <= (ctrl.tx_en && tx_avail) ? tx_head : 8'hFF;
                    end else begin
                        sy_tx <= {1'b1, sy_tx[7:1]};
                    end
                end
                if (sy_rise) begin
                    sy_rx <= {rxd_s, sy_rx[7:1]};
                    sy_cnt <= sy_cnt + 1'b1;
                    if (sy_cnt == FSP_LAST_BIT8) begin
                        sy_push <= ctrl.rx_en;
                        sy_word <= {rxd_s, sy_rx[7:1]};
                        sy_active <= 1'b0;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Error flags and break
    // ----------------------------------------
    assign fer_event = rxa_push & rxa_word.fer;

    // Hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ovr <= 1'b0;
            per_st <= 1'b0;
            fer_st <= 1'b0;
            brk <= 1'b0;
        end else begin
            // full buffer drops the new character
            ovr <= (rx_push & ~rx_in_ready) | (ovr & ~(st_wr & pwdata[FSP_ST_OVR]));
            per_st <= (rxa_push & rxa_word.per) | (per_st & ~(st_wr & pwdata[FSP_ST_PER]));
            fer_st <= fer_event | (fer_st & ~(st_wr & pwdata[FSP_ST_FER]));
            brk <= (brk_armed & ~rxd_s & tick16 & (brk_ticks == fsp_frame_ticks(ctrl)))
                 | (brk & ~(st_wr & pwdata[FSP_ST_BRK]));
        end
    end

    // one more full low frame after a framing error
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            brk_armed <= 1'b0;
            brk_ticks <= 8'h00;
        end else if (fer_event) begin
            brk_armed <= 1'b1;
            brk_ticks <= 8'h01;
        end else if (rxd_s || ctrl.sync_mode) begin
            brk_armed <= 1'b0;
        end else if (brk_armed && tick16) begin
            brk_ticks <= brk_ticks + 1'b1;
            if (brk_ticks == fsp_frame_ticks(ctrl)) begin
                brk_armed <= 1'b0;
            end
        end
    end

endmodule : fsp_fifo_serial_port

// >>> fsp_sp_asserts.sv
// Bus and line checker for the FIFO serial port
module fsp_sp_asserts
    import fsp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fsp_pkg::FSP_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxd,
    input wire logic txd,
    input wire logic sck_in,
    input wire logic sck_out,
    input wire logic sck_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_pready_once: assert property (pready |=> !pready)
        else $error("ready held");
    a_access_wait: assert property (psel && penable && !pready |=> pready)
        else $error("ready late");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_unmapped_err: assert property (psel && penable && !pready && paddr > 8'h10 |=> pslverr)
        else $error("unmapped not refused");
    a_txdata_zero: assert property (pready && !pwrite && paddr == 8'h08 |-> prdata == 0)
        else $error("send slot read not zero");
    // Shortest legal bit is two clocks
    a_start_low: assert property ($fell(txd) |=> !txd)
        else $error("start bit too short");
endmodule : fsp_sp_asserts

bind fsp_fifo_serial_port fsp_sp_asserts u_chk (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe(sck_oe));

// >>> fsp_sp_remote.sv
// Far-end model: loops the line back, can hold a break, can run the clock pin
module fsp_sp_remote (
    input wire logic clk_sys,
    input wire logic txd,
    input wire logic brk,
    input wire logic sck_run,
    output logic rxd,
    output logic sck_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div = 2'b00;
    always @(posedge clk_sys) begin
        div <= div + 2'b01;
    end
    assign rxd = brk ? 1'b0 : txd;
    // pin clock at a quarter of the system clock, high while stopped
    assign sck_in = sck_run ? div[1] : 1'b1;
endmodule : fsp_sp_remote

// >>> fsp_fifo_serial_port_tb.sv
// Bench for the FIFO serial port over APB with a loop-back line
module fsp_fifo_serial_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, brk = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic [3:0] f;
    logic sck_run = 1'b0;
    logic pready, pslverr, rxd, txd, sck_in, sck_out, sck_oe, e;
    int err_count = 0, checks_done = 0, cyc = 0;
    always #20 clk_sys = ~clk_sys;
    fsp_fifo_serial_port DUT (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .sck_in(sck_in), .sck_out(sck_out),
        .sck_oe(sck_oe));
    fsp_sp_remote u_remote (.clk_sys(clk_sys), .txd(txd), .brk(brk), .sck_run(sck_run),
        .rxd(rxd), .sck_in(sck_in));
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        checks_done++;
        if (s !== x) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, s, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    // Slow line events: read status until the bit shows
    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, 8'h10, 32'h0000_0000);
            n++;
        end while (r[b] !== 1'b1 && n < 3000);
    endtask : poll
    task print_verdict;
        $display("mismatches %0d comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            print_verdict();
        end
    end
    // ----
    // Sequence
    // ----
    initial begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, 8'h00, 0);
        chk(r, 32'h0000_0000);
        apb(1'b0, 8'h04, 0);
        chk(r, 32'h0000_000D);
        apb(1'b0, 8'h10, 0);
        chk(r, 32'h0000_0106);
        chk({sck_oe, sck_out, txd}, 3'b011);
        apb(1'b0, 8'h20, 0);
        chk({r[30:0], e}, 32'h0000_0001);
        apb(1'b1, 8'h04, 0);
        for (int i = 0; i < 8; i++) begin
            f = {i[2], i[1] & i[0], i[1], i[0]};
            apb(1'b1, 8'h00, {24'h0, 2'b11, 1'b0, f, 1'b0});
            apb(1'b1, 8'h08, 32'h0000_00A5 ^ i);
            poll(24);
            chk(r[24], 1'b1);
            apb(1'b0, 8'h0C, 0);
            chk(r, (32'h0000_00A5 ^ i) & (f[0] ? 32'h0000_007F : 32'h0000_00FF));
        end
        // Send side held off so its buffer fills up
        apb(1'b1, 8'h00, 32'h0000_0080);
        for (int i = 0; i < 17; i++) begin
            apb(1'b1, 8'h08, 32'h0000_0010 + i);
            chk(e, i == 16);
        end
        apb(1'b0, 8'h10, 0);
        chk(r & 32'h001F_0003, 32'h0010_0001);
        apb(1'b1, 8'h00, 32'h0000_00C0);
        poll(3);
        chk(r[3], 1'b1);
        apb(1'b1, 8'h08, 32'h0000_005A);
        poll(4);
        chk(r[4], 1'b1);
        for (int i = 0; i < 16; i++) begin
            apb(1'b0, 8'h0C, 0);
            chk(r, 32'h0000_0010 + i);
        end
        apb(1'b0, 8'h0C, 0);
        chk(r[31], 1'b1);
        apb(1'b1, 8'h10, 32'h0000_0010);
        apb(1'b0, 8'h10, 0);
        chk(r[4], 1'b0);
        brk <= 1'b1;
        poll(5);
        chk(r[5], 1'b1);
        chk(r & 32'h0000_01A0, 32'h0000_00A0);
        brk <= 1'b0;
        apb(1'b0, 8'h0C, 0);
        chk(r, 32'h0000_0200);
        // Parity flipped to odd while the even-parity character is on the line
        apb(1'b1, 8'h00, 32'h0000_00C4);
        apb(1'b1, 8'h08, 32'h0000_0001);
        apb(1'b1, 8'h00, 32'h0000_00CC);
        poll(24);
        chk(r[6], 1'b1);
        apb(1'b0, 8'h0C, 0);
        chk(r, 32'h0000_0101);
        // Sixteen-times tick taken from the clock pin
        sck_run <= 1'b1;
        apb(1'b1, 8'h00, 32'h0000_00E0);
        apb(1'b1, 8'h08, 32'h0000_00C3);
        poll(24);
        chk(r[24], 1'b1);
        apb(1'b0, 8'h0C, 0);
        chk(r, 32'h0000_00C3);
        // Sync loop-back needs a divider of 3 to cover the pin synchroniser
        sck_run <= 1'b0;
        apb(1'b1, 8'h04, 32'h0000_0003);
        apb(1'b1, 8'h00, 32'h0000_00C1);
        apb(1'b1, 8'h08, 32'h0000_003C);
        chk(sck_oe, 1'b1);
        poll(24);
        chk(r[24], 1'b1);
        apb(1'b0, 8'h0C, 0);
        chk(r, 32'h0000_003C);
        chk(sck_out, 1'b1);
        print_verdict();
    end
endmodule : fsp_fifo_serial_port_tb
